//--- rtl/cis_map.svh
// register map, field positions, reset values and timing figures
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH
`define CIS_A_CTRL 8'h00
`define CIS_A_EXT 8'h04
`define CIS_A_ROUTE 8'h08
`define CIS_A_SOCK 8'h10
`define CIS_A_STAT 8'h20
`define CIS_A_STEP 8'h04
`define CIS_CTRL_RST 32'h0000_0002
`define CIS_EXT_RST 32'h0000_0002
`define CIS_ROUTE_RST 32'h0000_00ff
`define CIS_SOCK_RST 32'h0000_0000
`define CIS_B_EXTCLK 0
`define CIS_B_LPD 1
`define CIS_B_SUSP 2
`define CIS_B_RING 7
`define CIS_B_AUTOOFF 1
`define CIS_B_CPCI 3
`define CIS_B_MPCI 4
`define CIS_B_SHARE 5
`define CIS_B_IO 4
`define CIS_B_RIA 5
`define CIS_B_RIB 7
`define CIS_B_VCC 8
`define CIS_B_VPP 9
`define CIS_B_V3 10
`define CIS_B_APA 12
`define CIS_B_APB 13
`define CIS_PIN_CLK 8
`define CIS_PIN_RING 9
`define CIS_PULSE_NS 100
`define CIS_CLK_NS 10
`endif

//--- rtl/cis_pkg.sv
// types shared by the interrupt steering and power mode block
package cis_pkg;
  typedef enum logic [1:0] {
    CIS_ACTIVE = 2'b00,
    CIS_LOWPWR = 2'b01,
    CIS_SUSPEND = 2'b10
  } cis_mode_t;
  typedef struct packed {
    logic cd1_b;
    logic cd2_b;
    logic rdy_irq_b;
    logic stschg_b;
    logic bvd2;
    logic vs1;
    logic vs2;
  } cis_sock_in_t;
  typedef struct packed {
    logic vcc5_en;
    logic vcc3_en;
    logic vpp1_en;
    logic vpp2_en;
  } cis_pwr_out_t;
endpackage : cis_pkg

//--- rtl/cis_top.sv
// interrupt steering, power modes and socket power switching
//
// Summary of operation
// - ten interrupt pins, each open-drain active-low or push-pull active-high
// - management interrupt pin goes open-drain active-low when its select is set
// - card interrupt pin goes open-drain active-low when its select is set
// - io card ready/irq raises card interrupt; status changes raise management class
// - four enabled management sources: detect, battery warn, battery dead, ready
// - card and management interrupts each steered to any of ten pins
// - shared push-pull pin pulses then floats instead of holding a level
// - pin eight becomes external clock input when its select bit is one
// - pin nine passes io card status change out as active-low ring
// - ring input accepted only with both socket ring enables set
// - low-power dynamic mode after reset; clearing its bit selects normal
// - idle low-power state gates clocks, holds card lines, keeps supplies
// - card activity, register access or detect change wakes, then sleeps again
// - suspend bit stops all clocks and outranks low-power dynamic mode
// - suspended: only control register writes accepted, card cycles ignored
// - suspended: interrupts still pass; supplies change only on card insertion or removal
// - six power control and sense pins per socket, software or automatic
// - card removal switches supplies off unless auto-off is cleared
// - both auto power bits set: insertion switches the socket supply on
`include "cis_map.svh"
module cis_top #(
  parameter int NSOCK = 2,
  parameter int PULSE_CYC = (`CIS_PULSE_NS + `CIS_CLK_NS - 1) / `CIS_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // socket pins
  input wire cis_pkg::cis_sock_in_t [NSOCK-1:0] sock_in,
  output cis_pkg::cis_pwr_out_t [NSOCK-1:0] sock_pwr,
  // card bus side
  input wire logic card_busy,
  output logic card_cycle_allow,
  output logic card_bus_hold,
  // clocking control
  output logic core_clk_en,
  output logic core_clk_src_ext,
  // interrupt pins
  output logic [9:0] irq_out,
  output logic [9:0] irq_oe_b
);
  import cis_pkg::*;
  localparam int W = 7 * NSOCK;
  localparam int PC = PULSE_CYC;

  // true when a route field names pin p
  function automatic logic pin_hit(input logic [3:0] sel, input int p);
    pin_hit = (sel == 4'(p));
  endfunction : pin_hit

  logic [31:0] ctrl_ff, ext_ff, route_ff;
  logic [W-1:0] s1_ff, s2_ff, s3_ff, filt_ff, prev_ff;
  cis_sock_in_t [NSOCK-1:0] fs, ps;
  cis_mode_t mode_ff, nxt_mode;
  logic [31:0] sock_rd [NSOCK];
  logic [31:0] stat_rd [NSOCK];
  logic [31:0] rd_word, prdata_ff;
  logic [NSOCK-1:0] present, insert, remove, cd_chg, cirq, ring_acc;
  logic card_irq, mgmt_irq, ring, activity, pin_active;
  logic [NSOCK-1:0] mflag_any;

  // apb decode; zero wait states, data registered in setup
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire hit_ctrl = (paddr == `CIS_A_CTRL);
  wire hit_ext = (paddr == `CIS_A_EXT);
  wire hit_route = (paddr == `CIS_A_ROUTE);
  wire susp_bit = ctrl_ff[`CIS_B_SUSP];
  logic [NSOCK-1:0] hit_sock, hit_stat;
  wire hit_any = hit_ctrl | hit_ext | hit_route | (|hit_sock) | (|hit_stat);
  wire refuse = susp_bit & ~hit_ctrl;
  wire wr = acc & pwrite & ~refuse;
  assign pready = 1'b1;
  assign pslverr = acc & (~hit_any | refuse);
  assign prdata = prdata_ff;

  // read data mux
  always_comb begin
    rd_word = 32'h0;
    if (hit_ctrl) rd_word = {22'h0, mode_ff, ctrl_ff[7:0]};
    if (hit_ext) rd_word = ext_ff;
    if (hit_route) rd_word = route_ff;
    for (int s = 0; s < NSOCK; s++) begin
      if (hit_sock[s]) rd_word = sock_rd[s];
      if (hit_stat[s]) rd_word = stat_rd[s];
    end
    if (refuse) rd_word = 32'h0;
  end

  // global registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `CIS_CTRL_RST;
      ext_ff <= `CIS_EXT_RST;
      route_ff <= `CIS_ROUTE_RST;
      prdata_ff <= 32'h0;
    end else begin
      if (wr && hit_ctrl) ctrl_ff <= {24'h0, pwdata[7:0] & 8'h87};
      if (wr && hit_ext) ext_ff <= pwdata & 32'h0000_003a;
      if (wr && hit_route) route_ff <= {24'h0, pwdata[7:0]};
      if (setup) prdata_ff <= rd_word;
    end
  end

  // pin inputs: three stages, change taken when stages two and three agree
  wire [W-1:0] raw = sock_in;
  wire [W-1:0] agree = ~(s2_ff ^ s3_ff);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= {W{1'b1}};
      s2_ff <= {W{1'b1}};
      s3_ff <= {W{1'b1}};
      filt_ff <= {W{1'b1}};
      prev_ff <= {W{1'b1}};
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= (agree & s2_ff) | (~agree & filt_ff);
      prev_ff <= filt_ff;
    end
  end
  assign fs = filt_ff;
  assign ps = prev_ff;

  // per socket configuration, status, flags and power
  generate
    for (genvar s = 0; s < NSOCK; s++) begin : g_sock
      logic [31:0] cfg_ff;
      logic [3:0] flag_ff, nxt_flag, ev;
      logic [1:0] pwr_ff, nxt_pwr;
      wire io = cfg_ff[`CIS_B_IO];
      wire was_in = ~ps[s].cd1_b & ~ps[s].cd2_b;
      assign hit_sock[s] = (paddr == 8'(`CIS_A_SOCK + s * 4));
      assign hit_stat[s] = (paddr == 8'(`CIS_A_STAT + s * 4));
      assign present[s] = ~fs[s].cd1_b & ~fs[s].cd2_b;
      assign insert[s] = present[s] & ~was_in;
      assign remove[s] = ~present[s] & was_in;
      assign cd_chg[s] = insert[s] | remove[s];
      // card interrupt from ready/irq of an io card
      assign cirq[s] = io & present[s] & ~fs[s].rdy_irq_b;
      // status change events, each gated by its enable
      assign ev[0] = cd_chg[s];
      assign ev[1] = ~io & (fs[s].bvd2 ^ ps[s].bvd2);
      assign ev[2] = fs[s].stschg_b ^ ps[s].stschg_b;
      assign ev[3] = ~io & (fs[s].rdy_irq_b ^ ps[s].rdy_irq_b);
      wire [3:0] clr = (wr && hit_stat[s]) ? pwdata[3:0] : 4'h0;
      assign nxt_flag = (flag_ff & ~clr) | (ev & cfg_ff[3:0]);
      assign mflag_any[s] = |flag_ff;
      // ring input accepted only with both ring enables
      assign ring_acc[s] = io & cfg_ff[`CIS_B_RIA] & cfg_ff[`CIS_B_RIB] & ~fs[s].stschg_b;
      // hardware power events win over a software write
      wire ap = cfg_ff[`CIS_B_APA] & cfg_ff[`CIS_B_APB];
      always_comb begin
        nxt_pwr = pwr_ff;
        if (wr && hit_sock[s]) nxt_pwr = pwdata[`CIS_B_VPP:`CIS_B_VCC];
        if (insert[s] && ap) nxt_pwr[0] = 1'b1;
        if (remove[s] && ext_ff[`CIS_B_AUTOOFF]) nxt_pwr = 2'b00;
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_ff <= `CIS_SOCK_RST;
          flag_ff <= 4'h0;
          pwr_ff <= 2'b00;
        end else begin
          if (wr && hit_sock[s]) cfg_ff <= pwdata & 32'h0000_34bf;
          flag_ff <= nxt_flag;
          pwr_ff <= nxt_pwr;
        end
      end
      wire v3 = cfg_ff[`CIS_B_V3];
      assign sock_pwr[s] = {pwr_ff[0] & ~v3, pwr_ff[0] & v3, pwr_ff[1], pwr_ff[1]};
      assign sock_rd[s] = {cfg_ff[31:10], pwr_ff, cfg_ff[7:0]};
      assign stat_rd[s] = {22'h0, fs[s].vs2, fs[s].vs1, pwr_ff, cirq[s], present[s], flag_ff};
    end
  endgenerate

  assign card_irq = |cirq;
  assign mgmt_irq = |mflag_any;
  assign ring = |ring_acc;

  // power mode: suspend first, then low-power when idle
  assign activity = card_busy | psel | (|cd_chg);
  always_comb begin
    nxt_mode = CIS_ACTIVE;
    case (1'b1)
      susp_bit: nxt_mode = CIS_SUSPEND;
      ctrl_ff[`CIS_B_LPD] && !activity: nxt_mode = CIS_LOWPWR;
      default: nxt_mode = CIS_ACTIVE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) mode_ff <= CIS_ACTIVE;
    else mode_ff <= nxt_mode;
  end
  assign core_clk_en = (mode_ff == CIS_ACTIVE);
  assign card_bus_hold = (mode_ff != CIS_ACTIVE);
  assign card_cycle_allow = (mode_ff != CIS_SUSPEND);
  assign core_clk_src_ext = ctrl_ff[`CIS_B_EXTCLK] & ~psel;

  // interrupt pins
  logic [9:0] req, pci;
  generate
    for (genvar p = 0; p < 10; p++) begin : g_pin
      logic req_q_ff;
      logic [7:0] cnt_ff;
      wire ch = pin_hit(route_ff[3:0], p);
      wire mh = pin_hit(route_ff[7:4], p);
      assign req[p] = (ch & card_irq) | (mh & mgmt_irq);
      assign pci[p] = (ch & ext_ff[`CIS_B_CPCI]) | (mh & ext_ff[`CIS_B_MPCI]);
      wire share = ext_ff[`CIS_B_SHARE] & ~pci[p];
      wire rise = req[p] & ~req_q_ff;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          req_q_ff <= 1'b0;
          cnt_ff <= 8'h0;
        end else begin
          req_q_ff <= req[p];
          if (rise && share) cnt_ff <= 8'(PC);
          else if (cnt_ff != 8'h0) cnt_ff <= cnt_ff - 8'h1;
        end
      end
      logic o, oeb;
      always_comb begin
        if (pci[p]) begin
          o = 1'b0;
          oeb = ~req[p];
        end else if (share) begin
          o = 1'b1;
          oeb = (cnt_ff == 8'h0);
        end else begin
          o = req[p];
          oeb = 1'b0;
        end
        if (p == `CIS_PIN_CLK && ctrl_ff[`CIS_B_EXTCLK]) begin
          o = 1'b0;
          oeb = 1'b1;
        end
        if (p == `CIS_PIN_RING && ctrl_ff[`CIS_B_RING]) begin
          o = ~ring;
          oeb = 1'b0;
        end
      end
      assign irq_out[p] = o;
      assign irq_oe_b[p] = oeb;
      property p_pulse;
        @(posedge clk) disable iff (!rst_b)
        (rise && share && !(p == `CIS_PIN_CLK || p == `CIS_PIN_RING)) |=>
          (cnt_ff != 8'h0) ##[PC:PC] (cnt_ff == 8'h0);
      endproperty
      a_pulse: assert property (p_pulse) else $error("share pulse length wrong");
    end
  endgenerate
  assign pin_active = |req;

  // checks
  property p_susp;
    @(posedge clk) disable iff (!rst_b)
    susp_bit |=> (mode_ff == CIS_SUSPEND) && !core_clk_en;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend did not stop clocks");
  property p_low;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_ff[`CIS_B_LPD] && !susp_bit && !activity) |=> !core_clk_en && card_bus_hold;
  endproperty
  a_low: assert property (p_low) else $error("idle did not enter low power");
  property p_wake;
    @(posedge clk) disable iff (!rst_b)
    (activity && !susp_bit) |=> core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("activity did not wake");
  property p_od;
    @(posedge clk) disable iff (!rst_b)
    (|(pci & req & 10'h0ff)) |-> ((irq_out | irq_oe_b) & pci & req & 10'h0ff) == 10'h0;
  endproperty
  a_od: assert property (p_od) else $error("open drain pin not pulled low");
  property p_ring;
    @(posedge clk) disable iff (!rst_b)
    ctrl_ff[`CIS_B_RING] |-> (irq_out[`CIS_PIN_RING] == !ring) && !irq_oe_b[`CIS_PIN_RING];
  endproperty
  a_ring: assert property (p_ring) else $error("ring output wrong");
  property p_ext;
    @(posedge clk) disable iff (!rst_b)
    ctrl_ff[`CIS_B_EXTCLK] |-> irq_oe_b[`CIS_PIN_CLK];
  endproperty
  a_ext: assert property (p_ext) else $error("clock pin driven");
  property p_off;
    @(posedge clk) disable iff (!rst_b)
    (remove[0] && ext_ff[`CIS_B_AUTOOFF]) |=> sock_pwr[0] == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("removal left power on");
  property p_on;
    @(posedge clk) disable iff (!rst_b)
    (insert[0] && !remove[0] && g_sock[0].ap) |=> (sock_pwr[0].vcc5_en || sock_pwr[0].vcc3_en);
  endproperty
  a_on: assert property (p_on) else $error("insertion left power off");
  property p_sticky;
    @(posedge clk) disable iff (!rst_b)
    (g_sock[0].ev[0] && g_sock[0].cfg_ff[0]) |=> g_sock[0].flag_ff[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status event lost");
  property p_refuse;
    @(posedge clk) disable iff (!rst_b)
    (acc && pwrite && susp_bit && hit_route) |=> $stable(route_ff);
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken in suspend");
  property p_flag_clr;
    @(posedge clk) disable iff (!rst_b)
    (wr && hit_stat[0] && pwdata[0] && !g_sock[0].ev[0]) |=> !g_sock[0].flag_ff[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("status flag not cleared");
  property p_pwr_susp;
    @(posedge clk) disable iff (!rst_b)
    (susp_bit && !(|cd_chg)) |=> $stable(sock_pwr);
  endproperty
  a_pwr_susp: assert property (p_pwr_susp) else $error("supply changed in suspend");
  property p_susp_rd;
    @(posedge clk) disable iff (!rst_b)
    (setup && susp_bit && !hit_ctrl) |=> (prdata == 32'h0);
  endproperty
  a_susp_rd: assert property (p_susp_rd) else $error("register read in suspend");
  c_pulse: cover property (@(posedge clk) disable iff (!rst_b) pin_active && ext_ff[`CIS_B_SHARE]);
  c_susp: cover property (@(posedge clk) disable iff (!rst_b) mode_ff == CIS_SUSPEND ##1 mode_ff == CIS_ACTIVE);
  c_ins: cover property (@(posedge clk) disable iff (!rst_b) insert[0] ##[1:50] remove[0]);
  c_ring: cover property (@(posedge clk) disable iff (!rst_b) ctrl_ff[`CIS_B_RING] && ring);
  c_ext: cover property (@(posedge clk) disable iff (!rst_b) core_clk_src_ext);
endmodule : cis_top

//--- tb/cis_irq_sink.sv
// system side of the interrupt pins: pulled-up lines seen by the interrupt controller
module cis_irq_sink (
  // pins from the block
  input wire logic [9:0] irq_out,
  input wire logic [9:0] irq_oe_b,
  // resolved line levels
  output logic [9:0] irq_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin floats to the board pull-up, a driven pin shows its level
  assign irq_line = (irq_oe_b & 10'h3ff) | (~irq_oe_b & irq_out);
endmodule : cis_irq_sink

//--- tb/card_irq_steering_power_modes_tb.sv
// self-checking bench for interrupt steering, power modes and socket power
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module card_irq_steering_power_modes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cis_pkg::*;
  localparam int PULSE = 4;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, card_busy;
  logic card_cycle_allow, card_bus_hold, core_clk_en, core_clk_src_ext, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  cis_sock_in_t [1:0] sock_in;
  cis_pwr_out_t [1:0] sock_pwr;
  logic [9:0] irq_out, irq_oe_b, line;
  int failures = 0;
  int checks_done = 0;
  int n, c, m, d;
  cis_top #(.NSOCK(2), .PULSE_CYC(PULSE)) uut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sock_in(sock_in), .sock_pwr(sock_pwr),
    .card_busy(card_busy), .card_cycle_allow(card_cycle_allow), .card_bus_hold(card_bus_hold),
    .core_clk_en(core_clk_en), .core_clk_src_ext(core_clk_src_ext), .irq_out(irq_out),
    .irq_oe_b(irq_oe_b));
  cis_irq_sink sink (.irq_out(irq_out), .irq_oe_b(irq_oe_b), .irq_line(line));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one apb transfer: setup, then access held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // let the pin synchronisers settle
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
  endtask : settle
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    #200us;
    failures++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, card_busy} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sock_in = {2{7'h7f}};
    void'($urandom(32'hfbd4a4c4));
    c = $urandom % 8;
    m = $urandom % 8;
    settle(2);
    rst_b <= 1'b1;
    // reset values and an unmapped place
    apb(1'b0, 8'h04, 32'h0);
    `CHK("ext", 32'h2, rd)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("route", 32'hff, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    $display("test reset ends");
    // random route words read back through the eight field bits
    repeat (8) begin
      d = $urandom;
      apb(1'b1, 8'h08, d);
      apb(1'b0, 8'h08, 32'h0);
      `CHK("route rand", d & 32'hff, rd)
    end
    $display("test route ends");
    // idle sleeps, card activity wakes
    settle(4);
    `CHK("clk en idle", 1'b0, core_clk_en)
    `CHK("hold idle", 1'b1, card_bus_hold)
    card_busy <= 1'b1;
    settle(3);
    `CHK("clk en busy", 1'b1, core_clk_en)
    card_busy <= 1'b0;
    $display("test lowpower ends");
    // insertion: auto power and management interrupt on an open-drain line
    apb(1'b1, 8'h10, 32'h3011);
    apb(1'b1, 8'h08, {24'h0, m[3:0], 4'hf});
    apb(1'b1, 8'h04, 32'h12);
    sock_in[0].cd1_b <= 1'b0;
    sock_in[0].cd2_b <= 1'b0;
    settle(8);
    `CHK("vcc on", 1'b1, sock_pwr[0].vcc5_en | sock_pwr[0].vcc3_en)
    `CHK("mgmt line", 1'b0, line[m])
    apb(1'b1, 8'h20, 32'hf);
    settle(2);
    `CHK("mgmt released", 1'b1, irq_oe_b[m])
    $display("test insert ends");
    // card interrupt push-pull, open-drain, then shared pulse
    apb(1'b1, 8'h08, {24'h0, 4'hf, c[3:0]});
    apb(1'b1, 8'h04, 32'h2);
    sock_in[0].rdy_irq_b <= 1'b0;
    settle(8);
    `CHK("pp out", 1'b1, irq_out[c])
    `CHK("pp oe", 1'b0, irq_oe_b[c])
    apb(1'b1, 8'h04, 32'ha);
    settle(2);
    `CHK("od out", 1'b0, irq_out[c])
    `CHK("od oe", 1'b0, irq_oe_b[c])
    sock_in[0].rdy_irq_b <= 1'b1;
    settle(8);
    `CHK("od release", 1'b1, line[c])
    apb(1'b1, 8'h04, 32'h22);
    sock_in[0].rdy_irq_b <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge clk);
      if (irq_oe_b[c] === 1'b0 && irq_out[c] === 1'b1) n++;
    end
    `CHK("pulse len", PULSE, n)
    `CHK("pulse float", 1'b1, irq_oe_b[c])
    $display("test card irq ends");
    // ring pass-through needs both socket enables; supply bit kept on
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b1, 8'h10, 32'h3131);
    sock_in[0].stschg_b <= 1'b0;
    settle(8);
    `CHK("ring one enable", 1'b1, line[9])
    apb(1'b1, 8'h10, 32'h31b1);
    settle(2);
    `CHK("ring out", 1'b0, line[9])
    sock_in[0].stschg_b <= 1'b1;
    $display("test ring ends");
    // suspend refuses other registers, interrupts and supplies stay
    apb(1'b1, 8'h04, 32'h2);
    apb(1'b1, 8'h00, 32'h6);
    settle(3);
    `CHK("susp clk", 1'b0, core_clk_en)
    `CHK("susp card", 1'b0, card_cycle_allow)
    apb(1'b1, 8'h08, 32'h55);
    `CHK("susp wr err", 1'b1, er)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("susp err", 1'b1, er)
    `CHK("susp rd", 32'h0, rd)
    `CHK("susp irq", 1'b1, irq_out[c])
    `CHK("susp vcc", 1'b1, sock_pwr[0].vcc5_en | sock_pwr[0].vcc3_en)
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("resume err", 1'b0, er)
    `CHK("route kept", 32'hf0 | c, rd)
    $display("test suspend ends");
    // external clock select releases pin eight while the bus is idle
    apb(1'b1, 8'h00, 32'h1);
    settle(1);
    `CHK("ext clk src", 1'b1, core_clk_src_ext)
    `CHK("clk pin off", 1'b1, irq_oe_b[8])
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl rd", 32'h1, rd)
    apb(1'b1, 8'h00, 32'h0);
    $display("test extclk ends");
    // software supply setting and read back, then removal switches supplies off
    apb(1'b1, 8'h10, 32'h3731);
    settle(1);
    `CHK("pwr sw", 4'h7, sock_pwr[0])
    apb(1'b0, 8'h10, 32'h0);
    `CHK("sock rd", 32'h3731, rd)
    sock_in[0].cd1_b <= 1'b1;
    sock_in[0].cd2_b <= 1'b1;
    settle(8);
    `CHK("vcc off", 4'h0, sock_pwr[0])
    $display("test removal ends");
    end_of_test();
  end
endmodule : card_irq_steering_power_modes_tb
